// ==== include/bscr_pkg.sv ====
package bscr_pkg;
   typedef enum logic {BSCR_FORWARD, BSCR_REVERSE} bscr_orient_type;

   // word offsets on the register bus
   localparam logic [7:0] OFS_BUS_NUMBERS = 8'h18;
   localparam logic [7:0] OFS_IO_STATUS   = 8'h1C;
   localparam logic [7:0] OFS_CONTROL     = 8'h40;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h44;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h48;

   // field positions in the 18h word
   localparam int SEC_BUS_LSB = 8;
   localparam int SUB_BUS_LSB = 16;
   localparam int LATENCY_LSB = 24;
   // field positions in the 1Ch word
   localparam int IO_BASE_LSB = 4;
   localparam int IO_LIM_LSB  = 12;
   localparam int CAP66_BIT   = 21;
   localparam int FBB_BIT     = 23;
   localparam int MDPE_BIT    = 24;
   // control word
   localparam int PERR_EN_BIT = 0;
   localparam int PCIX_BIT    = 1;
   localparam int REVERSE_BIT = 2;
   // interrupt word
   localparam int IRQ_W         = 2;
   localparam int IRQ_MDPE_BIT  = 0;
   localparam int IRQ_PERR_BIT  = 1;

   localparam logic [1:0] IO_CAP_CODE = 2'h1;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [3:0] NIBBLE_RST  = 4'h0;
   localparam logic       CAP66_RST   = 1'b1;
   localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;
   localparam int SYNC_STAGES = 3;
endpackage

// ==== src/bscr_perr_qual.sv ====
`timescale 1ns/100ps
module bscr_perr_qual (
   input  wire logic i_clk,            // core clock
   input  wire logic i_reset,          // sync reset, high
   input  wire logic i_enable,         // parity error response enable
   input  wire logic i_reverse,        // reverse orientation
   input  wire logic i_perr_seen,      // filtered downstream perr
   input  wire logic i_rd_perr,        // read data/split perr
   input  wire logic i_wr_active,      // write data or write split
   input  wire logic i_split_msg_perr, // split msg reports perr
   input  wire logic i_poisoned_cpl,   // poisoned completion
   input  wire logic i_poison_wr,      // write issued poisoned
   output logic      o_set             // flag set request
);
   logic fwd_cause;
   logic rev_cause;

   assign fwd_cause = i_rd_perr
                    | (i_perr_seen & i_wr_active)
                    | i_split_msg_perr;
   assign rev_cause = i_poisoned_cpl | i_poison_wr;
   // enable gates both orientations alike
   assign o_set = i_enable
                & (i_reverse ? rev_cause : fwd_cause);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   AST_SET_NEEDS_ENABLE: assert property (
      !i_enable |-> !o_set)
      else $error("flag set without parity response enable");
   AST_FWD_WRITE_PERR: assert property (
      i_enable && !i_reverse && i_perr_seen && i_wr_active |-> o_set)
      else $error("downstream perr during write not flagged");
   AST_REV_POISON: assert property (
      i_enable && i_reverse && (i_poisoned_cpl || i_poison_wr)
      |-> o_set)
      else $error("poisoned traffic not flagged in reverse");
   AST_REV_IGNORES_FWD: assert property (
      i_reverse && !i_poisoned_cpl && !i_poison_wr |-> !o_set)
      else $error("forward cause flagged in reverse");
endmodule

// ==== src/bscr_regs.sv ====
`timescale 1ns/100ps
// Function
// - secondary bus number, read-write, bits 15:8 of 18h, resets to 0
// - subordinate bus number, read-write, bits 23:16 of 18h, resets to 0
// - latency timer 31:24, writable only forward PCI mode, resets 0
// - both I/O bytes show code 01 in low bits, then two zeros
// - I/O base nibble bits 7:4 of 1Ch, writable, resets to 0
// - I/O limit nibble bits 15:12, low address bits ones, resets 0
// - 66 MHz capable bit reads one, reserved bits below read zero
// - fast back-to-back bit one forward PCI mode, zero in reverse
// - parity flag write-one-to-clear, set only with response enable
// - forward: set on parity error receiving read data or split
// - forward: set on downstream perr while writing or write split
// - forward: set on split message reporting non-posted write perr
// - reverse: set on poisoned completion or poisoned write issued
module bscr_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic              I_CLK,     // core clock, 100 MHz
   input  wire logic              I_RESET,   // sync reset, high
   input  wire logic              I_WB_CYC,  // wishbone cycle
   input  wire logic              I_WB_STB,  // wishbone strobe
   input  wire logic              I_WB_WE,   // wishbone write
   input  wire logic [ADDR_W-1:0] I_WB_ADR,  // byte address
   input  wire logic [3:0]        I_WB_SEL,  // byte enables
   input  wire logic [31:0]       I_WB_DAT,  // write data
   output logic      [31:0]       O_WB_DAT,  // read data
   output logic                   O_WB_ACK,  // cycle acknowledge
   input  wire logic              I_REVERSE_STRAP, // pin: reverse
   input  wire logic              I_PCIX_STRAP,    // pin: PCI-X mode
   input  wire logic              I_DOWNSTREAM_PARITY_ERROR_N, // pin
   input  wire logic              I_RD_PERR,       // read perr seen
   input  wire logic              I_WR_ACTIVE,     // write in flight
   input  wire logic              I_SPLIT_MSG_PERR,// split msg perr
   input  wire logic              I_POISONED_CPL,  // poisoned cpl
   input  wire logic              I_POISON_WR,     // poisoned write
   input  wire logic              I_IO_VALID,      // io address valid
   input  wire logic [31:0]       I_IO_ADDR,       // io address
   output logic                   O_IO_HIT,        // io forward
   output logic      [7:0]        O_SEC_BUS,       // secondary bus
   output logic      [7:0]        O_SUB_BUS,       // subordinate bus
   output logic      [7:0]        O_SEC_LATENCY,   // latency timer
   output logic                   O_MDPE,          // parity flag
   output logic                   O_IRQ            // interrupt level
);
   localparam int SN = bscr_pkg::SYNC_STAGES;

   // 3-stage synchronisers; no reset, data only
   logic [SN-1:0] rev_sync;
   logic [SN-1:0] pcix_sync;
   logic [SN-1:0] perr_sync;
   logic          rev_flt;
   logic          pcix_flt;
   logic          perr_flt;

   // a change counts once the last two stages agree
   function automatic logic settle(input logic [SN-1:0] s,
                                   input logic          cur);
      settle = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   function automatic logic lane(input logic       hit,
                                 input logic [3:0] sel,
                                 input int         idx);
      lane = hit & sel[idx];
   endfunction

   always_ff @(posedge I_CLK) begin
      rev_sync  <= {rev_sync[SN-2:0], I_REVERSE_STRAP};
      pcix_sync <= {pcix_sync[SN-2:0], I_PCIX_STRAP};
      perr_sync <= {perr_sync[SN-2:0], I_DOWNSTREAM_PARITY_ERROR_N};
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         perr_flt <= 1'b1;
      end else begin
         perr_flt <= settle(perr_sync, perr_flt);
      end
   end

   // straps are followed during reset and frozen at its release,
   // so orientation never moves under running software
   bscr_pkg::bscr_orient_type orient;
   logic                      pcix_mode;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         rev_flt  <= settle(rev_sync, rev_flt);
         pcix_flt <= settle(pcix_sync, pcix_flt);
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         orient    <= rev_flt ? bscr_pkg::BSCR_REVERSE
                              : bscr_pkg::BSCR_FORWARD;
         pcix_mode <= pcix_flt;
      end
   end

   wire is_reverse = (orient == bscr_pkg::BSCR_REVERSE);
   wire fwd_pci    = !is_reverse && !pcix_mode;

   // wishbone decode
   wire                req    = I_WB_CYC & I_WB_STB;
   wire                commit = req & O_WB_ACK & I_WB_WE;
   wire [ADDR_W-1:2]   word   = I_WB_ADR[ADDR_W-1:2];
   wire hit_bus  = (word == bscr_pkg::OFS_BUS_NUMBERS[ADDR_W-1:2]);
   wire hit_io   = (word == bscr_pkg::OFS_IO_STATUS[ADDR_W-1:2]);
   wire hit_ctl  = (word == bscr_pkg::OFS_CONTROL[ADDR_W-1:2]);
   wire hit_ist  = (word == bscr_pkg::OFS_IRQ_STATUS[ADDR_W-1:2]);
   wire hit_imsk = (word == bscr_pkg::OFS_IRQ_MASK[ADDR_W-1:2]);

   wire wr_sec   = lane(commit & hit_bus, I_WB_SEL, 1);
   wire wr_sub   = lane(commit & hit_bus, I_WB_SEL, 2);
   wire wr_lat   = lane(commit & hit_bus, I_WB_SEL, 3) & fwd_pci;
   wire wr_base  = lane(commit & hit_io, I_WB_SEL, 0);
   wire wr_lim   = lane(commit & hit_io, I_WB_SEL, 1);
   wire wr_stat  = lane(commit & hit_io, I_WB_SEL, 3);
   wire wr_ctl   = lane(commit & hit_ctl, I_WB_SEL, 0);
   wire wr_ist   = lane(commit & hit_ist, I_WB_SEL, 0);
   wire wr_imsk  = lane(commit & hit_imsk, I_WB_SEL, 0);

   logic [7:0]             sec_bus;
   logic [7:0]             sub_bus;
   logic [7:0]             latency;
   logic [3:0]             io_base;
   logic [3:0]             io_lim;
   logic                   perr_en;
   logic                   mdpe;
   logic [bscr_pkg::IRQ_W-1:0] irq_stat;
   logic [bscr_pkg::IRQ_W-1:0] irq_mask;
   logic                   perr_prev;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         sec_bus <= bscr_pkg::BYTE_RST;
         sub_bus <= bscr_pkg::BYTE_RST;
         latency <= bscr_pkg::BYTE_RST;
      end else begin
         if (wr_sec) sec_bus <= I_WB_DAT[15:8];
         if (wr_sub) sub_bus <= I_WB_DAT[23:16];
         if (wr_lat) latency <= I_WB_DAT[31:24];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         io_base <= bscr_pkg::NIBBLE_RST;
         io_lim  <= bscr_pkg::NIBBLE_RST;
         perr_en <= 1'b0;
      end else begin
         if (wr_base) io_base <= I_WB_DAT[7:4];
         if (wr_lim) io_lim <= I_WB_DAT[15:12];
         if (wr_ctl) perr_en <= I_WB_DAT[bscr_pkg::PERR_EN_BIT];
      end
   end

   // parity flag: hardware set wins over a same-cycle clear
   wire mdpe_set;
   wire mdpe_clr  = wr_stat & I_WB_DAT[bscr_pkg::MDPE_BIT];
   wire perr_seen = !perr_flt;
   wire perr_rise = perr_seen & !perr_prev;

   bscr_perr_qual u_qual (
      .i_clk            (I_CLK),
      .i_reset          (I_RESET),
      .i_enable         (perr_en),
      .i_reverse        (is_reverse),
      .i_perr_seen      (perr_seen),
      .i_rd_perr        (I_RD_PERR),
      .i_wr_active      (I_WR_ACTIVE),
      .i_split_msg_perr (I_SPLIT_MSG_PERR),
      .i_poisoned_cpl   (I_POISONED_CPL),
      .i_poison_wr      (I_POISON_WR),
      .o_set            (mdpe_set)
   );

   wire [bscr_pkg::IRQ_W-1:0] irq_evt = {perr_rise, mdpe_set};
   wire [bscr_pkg::IRQ_W-1:0] irq_clr =
      wr_ist ? I_WB_DAT[bscr_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         mdpe      <= 1'b0;
         irq_stat  <= '0;
         irq_mask  <= '0;
         perr_prev <= 1'b0;
      end else begin
         mdpe      <= (mdpe & !mdpe_clr) | mdpe_set;
         irq_stat  <= (irq_stat & ~irq_clr) | irq_evt;
         perr_prev <= perr_seen;
         if (wr_imsk) irq_mask <= I_WB_DAT[bscr_pkg::IRQ_W-1:0];
      end
   end

   // read words
   wire fbb = fwd_pci;
   wire [31:0] rd_bus = {latency, sub_bus, sec_bus, 8'h00};
   wire [15:0] sec_status = {7'h00, mdpe, fbb, 1'b0,
                             bscr_pkg::CAP66_RST, 5'h00};
   wire [31:0] rd_io = {sec_status,
                        io_lim, 2'b00, bscr_pkg::IO_CAP_CODE,
                        io_base, 2'b00, bscr_pkg::IO_CAP_CODE};
   wire [31:0] rd_ctl = {29'h0000_0000, is_reverse, pcix_mode, perr_en};
   wire [31:0] rd_ist = {30'h0000_0000, irq_stat};
   wire [31:0] rd_imsk = {30'h0000_0000, irq_mask};
   wire [31:0] rd_mux = hit_bus  ? rd_bus :
                        hit_io   ? rd_io  :
                        hit_ctl  ? rd_ctl :
                        hit_ist  ? rd_ist :
                        hit_imsk ? rd_imsk : 32'h0000_0000;

   // one wait state; unmapped words ack with zero, writes dropped
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
      end else begin
         O_WB_ACK <= req & !O_WB_ACK;
         if (req && !O_WB_ACK) O_WB_DAT <= rd_mux;
      end
   end

   // io window: limit covers its whole 4 KB page
   wire io_upper_ok = (I_IO_ADDR[31:16] == bscr_pkg::IO_UPPER_ZERO);
   wire io_in_win   = (I_IO_ADDR[15:12] >= io_base) &&
                      (I_IO_ADDR[15:12] <= io_lim);

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_IO_HIT <= 1'b0;
      end else begin
         O_IO_HIT <= I_IO_VALID & io_upper_ok & io_in_win;
      end
   end

   assign O_SEC_BUS     = sec_bus;
   assign O_SUB_BUS     = sub_bus;
   assign O_SEC_LATENCY = latency;
   assign O_MDPE        = mdpe;
   assign O_IRQ         = |(irq_stat & irq_mask);

   localparam int ACK_MIN = 1;
   localparam int ACK_MAX = 1;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   sequence s_read_io;
      req && !O_WB_ACK && !I_WB_WE && hit_io;
   endsequence
   sequence s_write_bus(int idx);
      req && O_WB_ACK && I_WB_WE && hit_bus && I_WB_SEL[idx];
   endsequence

   AST_SEC_BUS_RESET: assert property (
      $past(I_RESET) && !I_RESET |-> O_SEC_BUS == 8'h00)
      else $error("secondary bus number not zero after reset");
   AST_SUB_BUS_WRITE: assert property (
      s_write_bus(2) |=> O_SUB_BUS == $past(I_WB_DAT[23:16]))
      else $error("subordinate bus number write lost");
   AST_LATENCY_LOCKED: assert property (
      !fwd_pci |-> O_SEC_LATENCY == 8'h00)
      else $error("latency timer changed while read-only");
   AST_IO_CAP_READ: assert property (
      s_read_io ##1 O_WB_ACK |->
      O_WB_DAT[3:0] == 4'h1 && O_WB_DAT[11:8] == 4'h1)
      else $error("io capability code wrong");
   AST_IO_BASE_WRITE: assert property (
      wr_base |=> io_base == $past(I_WB_DAT[7:4]))
      else $error("io base write lost");
   AST_STATUS_CAPS: assert property (
      s_read_io ##1 O_WB_ACK |->
      O_WB_DAT[21:16] == 6'h20 && O_WB_DAT[23] == fbb)
      else $error("secondary status capability bits wrong");
   AST_FBB_ORIENT: assert property (
      is_reverse |-> !sec_status[7])
      else $error("fast back-to-back set in reverse");
   AST_MDPE_SET: assert property (
      mdpe_set |=> O_MDPE ##1 (O_MDPE || $past(mdpe_clr)))
      else $error("parity flag did not set and hold");
   AST_MDPE_ONLY_BY_CAUSE: assert property (
      !O_MDPE && !mdpe_set |=> !O_MDPE)
      else $error("parity flag set without cause");
   AST_MDPE_CLEAR: assert property (
      mdpe_clr && !mdpe_set |=> !O_MDPE)
      else $error("parity flag not cleared by write one");
   AST_FWD_READ_PERR: assert property (
      perr_en && !is_reverse && I_RD_PERR |=> O_MDPE)
      else $error("read parity error not flagged");
   AST_FWD_SPLIT_MSG: assert property (
      perr_en && !is_reverse && I_SPLIT_MSG_PERR |=> O_MDPE)
      else $error("split message parity error not flagged");
   AST_IO_WINDOW: assert property (
      I_IO_VALID && io_upper_ok && I_IO_ADDR[15:12] == io_lim
      && io_base <= io_lim |=> O_IO_HIT)
      else $error("io address at limit page not forwarded");
   AST_IO_UPPER: assert property (
      !io_upper_ok |=> !O_IO_HIT)
      else $error("io address above 64 KB forwarded");
   AST_WB_ACK: assert property (
      req && !O_WB_ACK |-> ##[ACK_MIN:ACK_MAX] O_WB_ACK ##1 !O_WB_ACK)
      else $error("wishbone ack timing wrong");
   AST_SEC_BUS_WRITE: assert property (
      s_write_bus(1) |=> O_SEC_BUS == $past(I_WB_DAT[15:8]))
      else $error("secondary bus number write lost");
   AST_SEC_BUS_HOLD: assert property (
      !wr_sec |=> $stable(O_SEC_BUS))
      else $error("secondary bus number changed without write");
   AST_SUB_BUS_HOLD: assert property (
      !wr_sub |=> $stable(O_SUB_BUS))
      else $error("subordinate bus number changed without write");
   AST_LATENCY_WRITE: assert property (
      s_write_bus(3) ##0 fwd_pci
      |=> O_SEC_LATENCY == $past(I_WB_DAT[31:24]))
      else $error("latency timer write lost in forward pci mode");
   AST_STRAPS_FROZEN: assert property (
      !I_RESET |=> $stable(orient) && $stable(pcix_mode))
      else $error("orientation moved outside reset");
   AST_IO_RESET: assert property (
      $past(I_RESET) && !I_RESET |-> io_base == 4'h0 && io_lim == 4'h0)
      else $error("io window fields not zero after reset");
   AST_IO_LIMIT_WRITE: assert property (
      wr_lim |=> io_lim == $past(I_WB_DAT[15:12]))
      else $error("io limit write lost");
   AST_IO_FIELDS_READ: assert property (
      s_read_io ##1 O_WB_ACK |->
      O_WB_DAT[15:12] == io_lim && O_WB_DAT[7:4] == io_base)
      else $error("io window fields read wrong");
   AST_MDPE_READ: assert property (
      s_read_io ##1 O_WB_ACK |-> O_WB_DAT[24] == $past(O_MDPE))
      else $error("parity flag read wrong");
   AST_IRQ_ON_SET: assert property (
      mdpe_set |=> irq_stat[bscr_pkg::IRQ_MDPE_BIT])
      else $error("parity flag event did not reach interrupt status");
   AST_WB_DATA_HOLD: assert property (
      O_WB_ACK |=> $stable(O_WB_DAT))
      else $error("read data moved after acknowledge");
endmodule

// ==== tb/bscr_far_side.sv ====
`timescale 1ns/100ps
// secondary bus agents: one event per go strobe
module bscr_far_side (
   input  wire logic       i_clk,          // core clock
   input  wire logic       i_go,           // start one event
   input  wire logic [2:0] i_cmd,          // which event
   output logic            o_rd_perr,      // read data parity error
   output logic            o_wr_active,    // write data in flight
   output logic            o_split_perr,   // split msg reports perr
   output logic            o_poisoned_cpl, // poisoned completion
   output logic            o_poison_wr,    // write issued poisoned
   output logic            o_perr_n        // downstream perr pin
);
   logic [3:0] cnt;

   initial begin
      cnt = 4'h0;
      o_rd_perr = 1'b0;
      o_split_perr = 1'b0;
      o_poisoned_cpl = 1'b0;
      o_poison_wr = 1'b0;
   end

   always @(posedge i_clk) begin
      o_rd_perr <= 1'b0;
      o_split_perr <= 1'b0;
      o_poisoned_cpl <= 1'b0;
      o_poison_wr <= 1'b0;
      if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
      if (i_go) begin
         case (i_cmd)
            3'h0: o_rd_perr <= 1'b1;
            3'h1: cnt <= 4'hC;
            3'h2: o_split_perr <= 1'b1;
            3'h3: o_poisoned_cpl <= 1'b1;
            default: o_poison_wr <= 1'b1;
         endcase
      end
   end

   // perr sits inside the write so the filtered copy still overlaps it
   assign o_wr_active = (cnt != 4'h0);
   // pulled-up pin: released means high
   assign o_perr_n = !(cnt > 4'h2 && cnt < 4'hB);
endmodule

// ==== tb/bridge_secondary_config_regs_bench.sv ====
`timescale 1ns/100ps
module bridge_secondary_config_regs_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic        rev = 1'b0;
   logic        pcix = 1'b0;
   logic        go = 1'b0;
   logic [2:0]  cmd = 3'h0;
   logic        io_valid = 1'b0;
   logic [31:0] io_addr = 32'h0000_0000;
   logic [31:0] rdat;
   logic        ack, perr_n, rd_perr, wr_act, split, pcpl, pwr;
   logic        io_hit, mdpe, irq;
   logic [7:0]  sbus, subus, slat;
   int          n_errors = 0;
   int          n_compared = 0;

   always #5 clk = !clk;

   bscr_regs #(.ADDR_W(8)) bscr_regs_i (
      .I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_REVERSE_STRAP(rev),
      .I_PCIX_STRAP(pcix), .I_DOWNSTREAM_PARITY_ERROR_N(perr_n),
      .I_RD_PERR(rd_perr), .I_WR_ACTIVE(wr_act),
      .I_SPLIT_MSG_PERR(split), .I_POISONED_CPL(pcpl),
      .I_POISON_WR(pwr), .I_IO_VALID(io_valid), .I_IO_ADDR(io_addr),
      .O_IO_HIT(io_hit), .O_SEC_BUS(sbus), .O_SUB_BUS(subus),
      .O_SEC_LATENCY(slat),
      .O_MDPE(mdpe), .O_IRQ(irq));

   bscr_far_side bscr_far_side_i (
      .i_clk(clk), .i_go(go), .i_cmd(cmd), .o_rd_perr(rd_perr),
      .o_wr_active(wr_act), .o_split_perr(split),
      .o_poisoned_cpl(pcpl), .o_poison_wr(pwr), .o_perr_n(perr_n));

   task automatic complete_run;
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
      check(rdat, exp);
   endtask

   task automatic ev(input logic [2:0] c);
      @(posedge clk);
      cmd <= c;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(posedge clk);
      #1;
   endtask

   task automatic io(input logic [31:0] a, input logic exp);
      @(posedge clk);
      io_valid <= 1'b1;
      io_addr <= a;
      @(posedge clk);
      io_valid <= 1'b0;
      #1;
      check({31'h0, io_hit}, {31'h0, exp});
   endtask

   task automatic do_reset(input logic r, input logic x);
      @(posedge clk);
      rst <= 1'b1;
      rev <= r;
      pcix <= x;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
   endtask

   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      complete_run;
   end

   initial begin
      do_reset(1'b0, 1'b0);
      rd(8'h18, 32'h0000_0000);
      rd(8'h1C, 32'h00A0_0101);
      wb(1'b1, 8'h18, 4'hF, 32'hFFFF_FFFF);
      rd(8'h18, 32'hFFFF_FF00);
      check({slat, subus, sbus, 8'h00}, 32'hFFFF_FF00);
      wb(1'b1, 8'h1C, 4'h3, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h00A0_F1F1);
      wb(1'b1, 8'h1C, 4'h3, 32'h0000_2010);
      rd(8'h1C, 32'h00A0_2111);
      io(32'h0000_1000, 1'b1);
      io(32'h0000_2FFF, 1'b1);
      io(32'h0000_0FFF, 1'b0);
      io(32'h0000_3000, 1'b0);
      io(32'h0001_1000, 1'b0);
      rd(8'h80, 32'h0000_0000);
      // flag must stay clear while response is disabled
      ev(3'h0);
      check({31'h0, mdpe}, 32'h0000_0000);
      wb(1'b1, 8'h40, 4'h1, 32'h0000_0001);
      for (int c = 0; c < 3; c++) begin
         ev(c[2:0]);
         check({31'h0, mdpe}, 32'h0000_0001);
         rd(8'h1C, 32'h01A0_2111);
         wb(1'b1, 8'h1C, 4'h8, 32'h0100_0000);
         #1;
         check({31'h0, mdpe}, 32'h0000_0000);
      end
      rd(8'h44, 32'h0000_0003);
      check({31'h0, irq}, 32'h0000_0000);
      wb(1'b1, 8'h48, 4'h1, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h0000_0001);
      wb(1'b1, 8'h44, 4'h1, 32'h0000_0003);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h0000_0000);
      rd(8'h44, 32'h0000_0000);
      // second reset with the orientation strap turned round
      do_reset(1'b1, 1'b0);
      check({slat, subus, sbus, 8'h00}, 32'h0000_0000);
      rd(8'h1C, 32'h0020_0101);
      rd(8'h40, 32'h0000_0004);
      wb(1'b1, 8'h18, 4'hF, 32'hFFFF_FFFF);
      rd(8'h18, 32'h00FF_FF00);
      check({slat, subus, sbus, 8'h00}, 32'h00FF_FF00);
      wb(1'b1, 8'h40, 4'h1, 32'h0000_0001);
      ev(3'h0);
      check({31'h0, mdpe}, 32'h0000_0000);
      for (int c = 3; c < 5; c++) begin
         ev(c[2:0]);
         check({31'h0, mdpe}, 32'h0000_0001);
         wb(1'b1, 8'h1C, 4'h8, 32'h0100_0000);
      end
      // forward with a pci-x secondary: latency read-only, no fbb
      do_reset(1'b0, 1'b1);
      rd(8'h1C, 32'h0020_0101);
      rd(8'h40, 32'h0000_0002);
      wb(1'b1, 8'h18, 4'hF, 32'hFFFF_FFFF);
      rd(8'h18, 32'h00FF_FF00);
      check({slat, subus, sbus, 8'h00}, 32'h00FF_FF00);
      complete_run;
   end
endmodule
